// File: rtl/ocu_top.v
// output compare unit: two compare channels, pin latches, special events, interrupt
// assumes timers, port latches and strobe bus all run on sys_clk
`timescale 1ns/1ps
`include "ocu_defines.vh"

module ocu_top (
    sys_clk,
    resetn,
    clk_en,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    timer_a_count,
    timer_b_count,
    port_latch_one,
    port_latch_two,
    unit_pin_one,
    unit_pin_two,
    special_event_one,
    special_event_two,
    timer_a_clear,
    timer_b_clear,
    adc_start,
    irq
);
    input  wire                    sys_clk;
    input  wire                    resetn;
    input  wire                    clk_en;
    input  wire [`OCU_ADDR_W-1:0]  reg_addr;
    input  wire [7:0]              reg_wdata;
    input  wire                    reg_wr;
    input  wire                    reg_rd;
    output reg  [7:0]              reg_rdata;
    input  wire [15:0]             timer_a_count;
    input  wire [15:0]             timer_b_count;
    input  wire                    port_latch_one;
    input  wire                    port_latch_two;
    output reg                     unit_pin_one;
    output reg                     unit_pin_two;
    output reg                     special_event_one;
    output reg                     special_event_two;
    output reg                     timer_a_clear;
    output reg                     timer_b_clear;
    output reg                     adc_start;
    output reg                     irq;

    // software registers
    reg  [7:0]  timer_b_config_q;
    reg  [15:0] compare_value_one_q;
    reg  [15:0] compare_value_two_q;
    reg  [7:0]  unit_one_control_q;
    reg  [5:0]  unit_two_control_q;
    reg  [1:0]  match_flag_q;
    reg  [1:0]  match_irq_enable_q;
    // compare output latches, separate from the port data latches
    reg         cmp_latch_one_q;
    reg         cmp_latch_two_q;

    wire [3:0]  mode_one;
    wire [3:0]  mode_two;
    wire        sel_low;
    wire        sel_high;
    wire        one_on_b;
    wire        two_on_b;
    wire [15:0] count_one;
    wire [15:0] count_two;
    wire        cmp_mode_one;
    wire        cmp_mode_two;
    wire        match_one;
    wire        match_two;
    wire        wr_ctrl2_zero;
    wire [1:0]  flag_set;
    wire [1:0]  flag_clr;
    wire [1:0]  flag_d;
    reg  [7:0]  rdata_d;
    reg         latch_one_d;
    reg         latch_two_d;
    reg         pin_one_d;
    reg         pin_two_d;
    reg         spec_one_d;
    reg         spec_two_d;
    reg         clear_a_d;
    reg         clear_b_d;
    reg  [1:0]  enable_d;
    reg         irq_d;

    function is_compare;
        input [3:0] m;
        begin
            is_compare = (m == `OCU_M_TOGGLE) || (m == `OCU_M_SET_HIGH) ||
                         (m == `OCU_M_SET_LOW) || (m == `OCU_M_SOFT_IRQ) ||
                         (m == `OCU_M_SPECIAL);
        end
    endfunction

    function drive_pin;
        input [3:0] m;
        begin
            drive_pin = (m == `OCU_M_TOGGLE) || (m == `OCU_M_SET_HIGH) ||
                        (m == `OCU_M_SET_LOW);
        end
    endfunction

    function next_latch;
        input [3:0] m;
        input       cur;
        begin
            case (m)
                `OCU_M_SET_HIGH: next_latch = 1'b1;
                `OCU_M_SET_LOW:  next_latch = 1'b0;
                `OCU_M_TOGGLE:   next_latch = ~cur;
                default:         next_latch = cur;
            endcase
        end
    endfunction

    assign mode_one = unit_one_control_q[`OCU_F_MODE_MSB:`OCU_F_MODE_LSB];
    assign mode_two = unit_two_control_q[`OCU_F_MODE_MSB:`OCU_F_MODE_LSB];

    // high selector gives timer b to both, low alone gives it to unit two only
    assign sel_low  = timer_b_config_q[`OCU_F_SEL_LOW];
    assign sel_high = timer_b_config_q[`OCU_F_SEL_HIGH];
    assign one_on_b = sel_high;
    assign two_on_b = sel_high | sel_low;
    assign count_one = one_on_b ? timer_b_count : timer_a_count;
    assign count_two = two_on_b ? timer_b_count : timer_a_count;

    assign cmp_mode_one = is_compare(mode_one);
    assign cmp_mode_two = is_compare(mode_two);

    ocu_cmp_chan u_chan_one (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .clk_en        (clk_en),
        .active        (cmp_mode_one),
        .timer_count   (count_one),
        .compare_value (compare_value_one_q),
        .match         (match_one)
    );

    ocu_cmp_chan u_chan_two (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .clk_en        (clk_en),
        .active        (cmp_mode_two),
        .timer_count   (count_two),
        .compare_value (compare_value_two_q),
        .match         (match_two)
    );

    assign wr_ctrl2_zero = reg_wr && (reg_addr == `OCU_A_CTRL2) && (reg_wdata == 8'h00);

    // set wins over a write-one clear in the same cycle
    assign flag_set = {match_two, match_one};
    assign flag_clr = (reg_wr && (reg_addr == `OCU_A_IRQ_STATUS)) ? reg_wdata[1:0] : 2'h0;
    assign flag_d   = (match_flag_q & ~flag_clr) | flag_set;

    always @* begin
        latch_one_d = cmp_latch_one_q;
        if (match_one) begin
            latch_one_d = next_latch(mode_one, cmp_latch_one_q);
        end
    end

    always @* begin
        latch_two_d = cmp_latch_two_q;
        if (wr_ctrl2_zero) begin
            latch_two_d = 1'b0;
        end else if (match_two) begin
            latch_two_d = next_latch(mode_two, cmp_latch_two_q);
        end
    end

    // soft interrupt and special event modes show the port latch
    always @* begin
        pin_one_d = port_latch_one;
        pin_two_d = port_latch_two;
        if (drive_pin(mode_one)) begin
            pin_one_d = latch_one_d;
        end
        if (drive_pin(mode_two)) begin
            pin_two_d = latch_two_d;
        end
    end

    // both units may share a timer, so either event can clear it
    always @* begin
        spec_one_d = match_one && (mode_one == `OCU_M_SPECIAL);
        spec_two_d = match_two && (mode_two == `OCU_M_SPECIAL);
        clear_a_d  = 1'b0;
        clear_b_d  = 1'b0;
        if (spec_one_d) begin
            if (one_on_b) begin
                clear_b_d = 1'b1;
            end else begin
                clear_a_d = 1'b1;
            end
        end
        if (spec_two_d) begin
            if (two_on_b) begin
                clear_b_d = 1'b1;
            end else begin
                clear_a_d = 1'b1;
            end
        end
    end

    // a mask written this cycle counts at once, so irq never lags the mask
    always @* begin
        enable_d = match_irq_enable_q;
        if (reg_wr && (reg_addr == `OCU_A_IRQ_ENABLE)) begin
            enable_d = reg_wdata[1:0];
        end
        irq_d = |(flag_d & enable_d);
    end

    always @* begin
        rdata_d = 8'h00;
        case (reg_addr)
            `OCU_A_TIMER_B_CFG: rdata_d = timer_b_config_q;
            `OCU_A_CMP1_LO:     rdata_d = compare_value_one_q[7:0];
            `OCU_A_CMP1_HI:     rdata_d = compare_value_one_q[15:8];
            `OCU_A_CTRL1:       rdata_d = unit_one_control_q;
            `OCU_A_CMP2_LO:     rdata_d = compare_value_two_q[7:0];
            `OCU_A_CMP2_HI:     rdata_d = compare_value_two_q[15:8];
            `OCU_A_CTRL2:       rdata_d = {2'b00, unit_two_control_q};
            `OCU_A_IRQ_STATUS:  rdata_d = {6'h00, match_flag_q};
            `OCU_A_IRQ_ENABLE:  rdata_d = {6'h00, match_irq_enable_q};
            default:            rdata_d = 8'h00;
        endcase
    end

    // register writes
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timer_b_config_q    <= `OCU_RST_BYTE;
            compare_value_one_q <= {`OCU_RST_BYTE, `OCU_RST_BYTE};
            compare_value_two_q <= {`OCU_RST_BYTE, `OCU_RST_BYTE};
            unit_one_control_q  <= `OCU_RST_BYTE;
            unit_two_control_q  <= `OCU_RST_CTRL2;
            match_irq_enable_q  <= `OCU_RST_IRQ;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `OCU_A_TIMER_B_CFG: timer_b_config_q          <= reg_wdata;
                `OCU_A_CMP1_LO:     compare_value_one_q[7:0]  <= reg_wdata;
                `OCU_A_CMP1_HI:     compare_value_one_q[15:8] <= reg_wdata;
                `OCU_A_CTRL1:       unit_one_control_q        <= reg_wdata;
                `OCU_A_CMP2_LO:     compare_value_two_q[7:0]  <= reg_wdata;
                `OCU_A_CMP2_HI:     compare_value_two_q[15:8] <= reg_wdata;
                `OCU_A_CTRL2:       unit_two_control_q        <= reg_wdata[`OCU_F_CTRL2_MSB:0];
                `OCU_A_IRQ_ENABLE:  match_irq_enable_q        <= reg_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // match state, pins, events and interrupt
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            match_flag_q      <= `OCU_RST_IRQ;
            cmp_latch_one_q   <= 1'b0;
            cmp_latch_two_q   <= 1'b0;
            unit_pin_one      <= 1'b0;
            unit_pin_two      <= 1'b0;
            special_event_one <= 1'b0;
            special_event_two <= 1'b0;
            timer_a_clear     <= 1'b0;
            timer_b_clear     <= 1'b0;
            adc_start         <= 1'b0;
            irq               <= 1'b0;
            reg_rdata         <= 8'h00;
        end else if (clk_en) begin
            match_flag_q    <= flag_d;
            cmp_latch_one_q <= latch_one_d;
            cmp_latch_two_q <= latch_two_d;
            unit_pin_one      <= pin_one_d;
            unit_pin_two      <= pin_two_d;
            special_event_one <= spec_one_d;
            special_event_two <= spec_two_d;
            timer_a_clear     <= clear_a_d;
            timer_b_clear     <= clear_b_d;
            // converter ignores this pulse unless software enabled it
            adc_start         <= spec_two_d;
            irq               <= irq_d;
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end
endmodule // ocu_top

// File: rtl/ocu_defines.vh
// constants for the output compare unit: register indices, fields, resets, modes
// assumes byte-wide registers reached over a plain strobe port
`ifndef OCU_DEFINES_VH
`define OCU_DEFINES_VH

// register indices on the strobe port
`define OCU_ADDR_W            4
`define OCU_A_TIMER_B_CFG     4'h0
`define OCU_A_CMP1_LO         4'h1
`define OCU_A_CMP1_HI         4'h2
`define OCU_A_CTRL1           4'h3
`define OCU_A_CMP2_LO         4'h4
`define OCU_A_CMP2_HI         4'h5
`define OCU_A_CTRL2           4'h6
`define OCU_A_IRQ_STATUS      4'h7
`define OCU_A_IRQ_ENABLE      4'h8

// field positions
`define OCU_F_SEL_LOW         3
`define OCU_F_SEL_HIGH        6
`define OCU_F_MODE_MSB        3
`define OCU_F_MODE_LSB        0
`define OCU_F_CTRL2_MSB       5
`define OCU_F_FLAG1           0
`define OCU_F_FLAG2           1

// reset values
`define OCU_RST_BYTE          8'h00
`define OCU_RST_CTRL2         6'h00
`define OCU_RST_IRQ           2'h0

// compare modes of the mode select field
`define OCU_M_TOGGLE          4'h2
`define OCU_M_SET_HIGH        4'h8
`define OCU_M_SET_LOW         4'h9
`define OCU_M_SOFT_IRQ        4'ha
`define OCU_M_SPECIAL         4'hb

`endif

// File: rtl/ocu_cmp_chan.v
// one compare channel: 16-bit equality against a timer, edge of equality only
// assumes timer count and compare value come from logic on sys_clk
`timescale 1ns/1ps

module ocu_cmp_chan (
    sys_clk,
    resetn,
    clk_en,
    active,
    timer_count,
    compare_value,
    match
);
    input  wire        sys_clk;
    input  wire        resetn;
    input  wire        clk_en;
    input  wire        active;
    input  wire [15:0] timer_count;
    input  wire [15:0] compare_value;
    output wire        match;

    wire equal;
    reg  equal_q;

    assign equal = (timer_count == compare_value);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            equal_q <= 1'b0;
        end else if (clk_en) begin
            equal_q <= equal;
        end
    end

    // a count parked on the value must not fire every cycle
    assign match = active & equal & ~equal_q;
endmodule // ocu_cmp_chan

// File: tb/ocu_far_model.sv
// timers and converter that sit beside the compare unit
// assumes one clock; the bench parks the counts by loading them
`timescale 1ns/1ps

module ocu_far_model (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        ld,
    input  wire [15:0] va,
    input  wire [15:0] vb,
    input  wire        timer_a_clear,
    input  wire        timer_b_clear,
    input  wire        adc_start,
    input  wire        adc_on,
    output reg  [15:0] timer_a_count,
    output reg  [15:0] timer_b_count,
    output reg  [7:0]  adc_runs
);
    // counts change only on sys_clk or on the asynchronous active-low resetn
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timer_a_count <= 16'h0000;
            timer_b_count <= 16'h0000;
            adc_runs      <= 8'h00;
        end else begin
            timer_a_count <= timer_a_clear ? 16'h0000 : ld ? va : timer_a_count;
            timer_b_count <= timer_b_clear ? 16'h0000 : ld ? vb : timer_b_count;
            // a start is lost unless software enabled the converter
            if (adc_start && adc_on)
                adc_runs <= adc_runs + 8'h01;
        end
    end
endmodule // ocu_far_model

// File: tb/ocu_top_sva.sv
// port checks for the compare unit, bound in below
// assumes one clock sys_clk and async active-low resetn
`timescale 1ns/1ps
`include "ocu_defines.vh"

module ocu_top_sva (
    input wire                   sys_clk,
    input wire                   resetn,
    input wire                   clk_en,
    input wire [`OCU_ADDR_W-1:0] reg_addr,
    input wire                   reg_wr,
    input wire                   reg_rd,
    input wire [7:0]             reg_rdata,
    input wire                   special_event_one,
    input wire                   special_event_two,
    input wire                   timer_a_clear,
    input wire                   timer_b_clear,
    input wire                   adc_start,
    input wire                   irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // equality must leave and come back, so an event never stands twice
    AST_SE_ONE_PULSE: assert property (special_event_one && clk_en |=> !special_event_one)
        else $error("unit one event held");
    AST_SE_TWO_PULSE: assert property ($rose(special_event_two) && clk_en |=> $fell(special_event_two))
        else $error("unit two event not a pulse");
    AST_CLR_CAUSE: assert property (timer_a_clear || timer_b_clear |-> special_event_one || special_event_two)
        else $error("timer clear without event");
    AST_SE_CLEARS: assert property (special_event_one |-> timer_a_clear || timer_b_clear)
        else $error("event did not clear a timer");
    AST_ADC_START: assert property (adc_start == special_event_two)
        else $error("converter start differs from unit two event");
    AST_CTRL2_TOP: assert property (reg_rd && clk_en && reg_addr == `OCU_A_CTRL2 |=> reg_rdata[7:6] == 2'b00)
        else $error("unit two control upper bits not zero");
    AST_RDATA_IDLE: assert property (!reg_rd && clk_en |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(reg_wr) && ($past(reg_addr) == `OCU_A_IRQ_STATUS
        || $past(reg_addr) == `OCU_A_IRQ_ENABLE))
        else $error("interrupt dropped without software write");
endmodule // ocu_top_sva

bind ocu_top ocu_top_sva u_sva (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .special_event_one(special_event_one), .special_event_two(special_event_two),
    .timer_a_clear(timer_a_clear), .timer_b_clear(timer_b_clear), .adc_start(adc_start)
);

// File: tb/output_compare_unit_tb_top.sv
// random and corner-case bench for the compare unit
// assumes the far-side model and the bound checker
`timescale 1ns/1ps
`include "ocu_defines.vh"

module output_compare_unit_tb_top;
    reg         sys_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         clk_en = 1'b1;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [1:0]  pl = 2'b00;
    reg         ld = 1'b0;
    reg  [15:0] va = 16'h0000;
    reg  [15:0] vb = 16'h0000;
    wire [7:0]  reg_rdata;
    wire [15:0] cnt_a;
    wire [15:0] cnt_b;
    wire [1:0]  pin;
    wire [1:0]  se;
    wire        ca;
    wire        cb;
    wire        adc;
    wire        irq;
    wire [7:0]  runs;
    integer     mismatches = 0;
    integer     checks_done = 0;
    integer     u;
    integer     i;
    integer     k;
    reg  [31:0] r;
    reg  [15:0] d;
    reg  [15:0] v;
    reg  [3:0]  m;
    reg  [3:0]  b3;
    reg  [7:0]  ae = 8'h00;
    reg  [1:0]  lat = 2'b00;
    reg  [7:0]  es = 8'h00;
    reg  [7:0]  se_cnt = 8'h00;
    reg         sel;
    wire [23:0] tbl = {4'h0, `OCU_M_SPECIAL, `OCU_M_SOFT_IRQ, `OCU_M_SET_LOW,
                       `OCU_M_SET_HIGH, `OCU_M_TOGGLE};

    always #50 sys_clk = ~sys_clk;

    // event pulses last one cycle, so count them as they pass
    always @(posedge sys_clk) begin
        if (resetn)
            se_cnt <= se_cnt + {7'h00, se[0]} + {7'h00, se[1]};
    end

    ocu_top dut (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_a_count(cnt_a), .timer_b_count(cnt_b), .port_latch_one(pl[0]),
        .port_latch_two(pl[1]), .unit_pin_one(pin[0]), .unit_pin_two(pin[1]),
        .special_event_one(se[0]), .special_event_two(se[1]), .timer_a_clear(ca),
        .timer_b_clear(cb), .adc_start(adc), .irq(irq)
    );
    ocu_far_model u_far (
        .sys_clk(sys_clk), .resetn(resetn), .ld(ld), .va(va), .vb(vb), .timer_a_clear(ca),
        .timer_b_clear(cb), .adc_start(adc), .adc_on(1'b1), .timer_a_count(cnt_a),
        .timer_b_count(cnt_b), .adc_runs(runs)
    );

    function hit(input [3:0] x);
        hit = (x == `OCU_M_TOGGLE) || (x[3:2] == 2'b10);
    endfunction
    function drv(input [3:0] x);
        drv = (x == `OCU_M_TOGGLE) || (x[3:1] == 3'b100);
    endfunction
    function nxt(input [3:0] x, input l);
        nxt = (x == `OCU_M_TOGGLE) ? ~l : (x == `OCU_M_SET_HIGH) ? 1'b1
            : (x == `OCU_M_SET_LOW) ? 1'b0 : l;
    endfunction

    task chk(input [15:0] e, input [15:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] w);
        begin
            @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= w;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            @(negedge sys_clk);
            d = {8'h00, reg_rdata};
            @(posedge sys_clk);
        end
    endtask
    // selected timer gets x, the other one a value that never matches
    task ldt(input [15:0] x);
        begin
            @(posedge sys_clk);
            ld <= 1'b1;
            va <= sel ? ~v : x;
            vb <= sel ? x : ~v;
            @(posedge sys_clk);
            ld <= 1'b0;
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    initial begin
        #1_000_000;
        mismatches = mismatches + 1;
        test_done;
    end

    initial begin
        r = $urandom(32'hd6f232ac);
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        for (k = 0; k < 6; k = k + 1) begin
            r = $urandom;
            if (k != 3) begin
                wr(k[3:0], r[7:0]);
                rd(k[3:0]);
                chk({8'h00, r[7:0]}, d);
            end
        end
        // mode f never matches, so control bits can be probed freely
        wr(`OCU_A_CTRL1, r[7:0] | 8'h0f);
        rd(`OCU_A_CTRL1);
        chk({8'h00, r[7:0] | 8'h0f}, d);
        wr(`OCU_A_CTRL2, r[7:0] | 8'h0f);
        rd(`OCU_A_CTRL2);
        chk({10'h000, r[5:4], 4'hf}, d);
        wr(`OCU_A_IRQ_ENABLE, 8'hff);
        rd(`OCU_A_IRQ_ENABLE);
        chk(16'h0003, d);
        // a write while the enable is low must be lost
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(`OCU_A_IRQ_ENABLE, 8'h00);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(`OCU_A_IRQ_ENABLE);
        chk(16'h0003, d);
        rd(4'h9 + r[9:8]);
        chk(16'h0000, d);
        for (i = 0; i < 24; i = i + 1) begin
            u = i % 2;
            b3 = (u == 1) ? 4'h3 : 4'h0;
            m = tbl[4 * ((i / 2) % 6) +: 4];
            r = $urandom;
            v = r[15:0];
            pl <= r[18:17];
            sel = i[2] | (i[3] & (u == 1));
            wr(`OCU_A_CTRL1, 8'h00);
            wr(`OCU_A_CTRL2, 8'h00);
            lat[1] = 1'b0;
            wr(`OCU_A_TIMER_B_CFG, {1'b0, i[2], 2'b00, i[3], 3'b000});
            ldt(v + 16'h0001);
            wr(`OCU_A_CMP1_LO + b3, v[7:0]);
            wr(`OCU_A_CMP1_HI + b3, v[15:8]);
            wr(`OCU_A_IRQ_STATUS, 8'h03);
            wr(`OCU_A_IRQ_ENABLE, {7'h00, r[16]} << u);
            wr(`OCU_A_CTRL1 + b3, {4'h0, m});
            repeat (2) @(posedge sys_clk);
            chk({15'h0000, drv(m) ? lat[u] : pl[u]}, {15'h0000, pin[u]});
            ldt(v);
            repeat (3) @(posedge sys_clk);
            if (hit(m))
                lat[u] = nxt(m, lat[u]);
            if (m == `OCU_M_SPECIAL && u == 1)
                ae = ae + 8'h01;
            if (m == `OCU_M_SPECIAL)
                es = es + 8'h01;
            chk({15'h0000, drv(m) ? lat[u] : pl[u]}, {15'h0000, pin[u]});
            chk({15'h0000, hit(m) & r[16]}, {15'h0000, irq});
            chk(m == `OCU_M_SPECIAL ? 16'h0000 : v, sel ? cnt_b : cnt_a);
            chk(~v, sel ? cnt_a : cnt_b);
            chk({8'h00, ae}, {8'h00, runs});
            chk({8'h00, es}, {8'h00, se_cnt});
            rd(`OCU_A_IRQ_STATUS);
            chk({14'h0000, hit(m) & (u == 1), hit(m) & (u == 0)}, d);
            wr(`OCU_A_IRQ_STATUS, 8'h03);
            rd(`OCU_A_IRQ_STATUS);
            chk(16'h0000, d);
            chk(16'h0000, {15'h0000, irq});
        end
        test_done;
    end
endmodule // output_compare_unit_tb_top
